// file: logic/quadrature_pulse_output_regs.svh
// timing and scaling constants of the encoder emulation output stage
`ifndef QUADRATURE_PULSE_OUTPUT_REGS_SVH
`define QUADRATURE_PULSE_OUTPUT_REGS_SVH

// core clock rate in hertz
`define QPO_CLK_HZ 40000000
// rated track A frequency in frequency-plus-sign mode, hertz
`define QPO_RATED_HZ 100000
// setpoint magnitude (top ten bits) that means full scale
`define QPO_FULL_SCALE 10'h100
// largest magnitude passed on, about 112 percent
`define QPO_MAG_MAX 10'h11f
// setpoint field taken from the 32-bit word
`define QPO_SP_MSB 31
`define QPO_SP_LSB 22
// level of the synchronised strap that keeps quadrature mode
`define QPO_STRAP_QUAD 1'b1
// edge ticks per second at full scale: two per track A period
`define QPO_TICK_HZ (2 * `QPO_RATED_HZ)
// phase modulus: clock cycles per tick times full-scale magnitude
`define QPO_PHASE_MOD ((`QPO_CLK_HZ / `QPO_TICK_HZ) * 256)
// reset values of the two track levels
`define QPO_RST_A 1'b0
`define QPO_RST_B 1'b0

`endif

// file: logic/quadrature_pulse_output_pkg.sv
// types shared by the encoder emulation output stage
`default_nettype none

package quadrature_pulse_output_pkg;

    // output format selected by the strap
    typedef enum logic {
        MODE_QUAD,
        MODE_FREQ_SIGN
    } mode_t;

    // setpoint word and its load strobe from the ring bus receiver
    typedef struct packed {
        logic [31:0] value;
        logic sync;
    } setpoint_t;

    // complementary driver pairs of the two tracks
    typedef struct packed {
        logic a_p;
        logic a_n;
        logic b_p;
        logic b_n;
    } enc_pins_t;

endpackage

`default_nettype wire

// file: logic/edge_rate_generator.sv
// modulo phase accumulator that emits edge ticks at a rate set by magnitude
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_pulse_output_regs.svh"

module edge_rate_generator
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // rate request
    input wire logic [9:0] magnitude,
    // one-cycle tick per frequency-mode edge; every second tick is a quadrature edge
    output logic tick
);

    localparam logic [16:0] PHASE_MOD = 17'(`QPO_PHASE_MOD);

    logic [16:0] phase_ff;
    logic [16:0] nxt_phase;
    logic [17:0] sum;
    logic tick_ff;

    // -----------------------------------------------------------------
    // accumulator
    // -----------------------------------------------------------------
    // a modulus instead of a power of two keeps the rate exact at 40 MHz
    always_comb
    begin
        sum = {1'b0, phase_ff} + {8'h00, magnitude};
        if (sum >= {1'b0, PHASE_MOD})
        begin
            nxt_phase = 17'(sum - {1'b0, PHASE_MOD});
        end
        else
        begin
            nxt_phase = sum[16:0];
        end
    end

    // phase register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_ff <= 17'h00000;
        end
        else
        begin
            phase_ff <= nxt_phase;
        end
    end

    // tick when the accumulator wraps; zero magnitude never wraps
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (sum >= {1'b0, PHASE_MOD}); // R9
        end
    end

    assign tick = tick_ff;

endmodule // edge_rate_generator
`default_nettype wire

// file: logic/quadrature_pulse_output.sv
// top of the encoder emulation output stage
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_pulse_output_regs.svh"

// Summary of operation
// R1 - an open strap pin, pulled high, keeps the two-track quadrature mode.
// R2 - tying the strap pin to ground switches the output to frequency plus sign.
// R3 - each track leaves as a true signal and its inverse from flip-flops.
// R4 - in quadrature mode both tracks share one rate, B a quarter period off A.
// R5 - in quadrature mode each track stays high and low for equal times.
// R6 - A leads B for positive setpoints and B leads A for negative ones.
// R7 - in frequency mode track A runs four times faster, 100 kHz at full scale.
// R8 - in frequency mode track B is low for positive and high for negative.
// R9 - quadrature tracks run at 25 kHz at full scale, linear in magnitude.
// R10 - only the ten top setpoint bits count and 4000 0000 hex is full scale.
// R11 - a new setpoint is loaded on each sync strobe, keeping phase order.
// R12 - magnitudes beyond about 112 percent are clamped to the top rate.
module quadrature_pulse_output
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // setpoint from the ring bus receiver, same clock domain
    input wire quadrature_pulse_output_pkg::setpoint_t setpoint,
    // mode strap pin, pulled up outside the chip
    input wire logic mode_strap_input,
    // encoder driver pairs
    output quadrature_pulse_output_pkg::enc_pins_t enc_pins,
    // format currently in force
    output quadrature_pulse_output_pkg::mode_t mode
);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // magnitude of the ten-bit signed field, clamped to the top rate
    function automatic logic [9:0] clamp_mag(input logic [9:0] field);
        logic [9:0] mag;
        begin
            mag = field[9] ? 10'(~field + 10'h001) : field; // R10
            if (mag > `QPO_MAG_MAX)
            begin
                mag = `QPO_MAG_MAX; // R12
            end
            return mag;
        end
    endfunction

    // -----------------------------------------------------------------
    // strap synchroniser
    // -----------------------------------------------------------------
    logic strap_meta_ff;
    logic strap_sync_ff;

    // the pin is asynchronous; pulled high (open) reads as quadrature
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strap_meta_ff <= `QPO_STRAP_QUAD;
            strap_sync_ff <= `QPO_STRAP_QUAD;
        end
        else
        begin
            strap_meta_ff <= mode_strap_input;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    quadrature_pulse_output_pkg::mode_t mode_ff;

    // format register follows the synchronised strap
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_ff <= quadrature_pulse_output_pkg::MODE_QUAD;
        end
        else if (strap_sync_ff == `QPO_STRAP_QUAD)
        begin
            mode_ff <= quadrature_pulse_output_pkg::MODE_QUAD; // R1
        end
        else
        begin
            mode_ff <= quadrature_pulse_output_pkg::MODE_FREQ_SIGN; // R2
        end
    end

    // -----------------------------------------------------------------
    // setpoint capture
    // -----------------------------------------------------------------
    logic [9:0] mag_ff;
    logic negative_ff;

    // the rate changes only at a strobe, so a word in flight is never seen
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mag_ff <= 10'h000;
            negative_ff <= 1'b0;
        end
        else if (setpoint.sync)
        begin
            mag_ff <= clamp_mag(
                setpoint.value[`QPO_SP_MSB:`QPO_SP_LSB]); // R11
            negative_ff <= setpoint.value[`QPO_SP_MSB];
        end
    end

    // -----------------------------------------------------------------
    // edge rate generator
    // -----------------------------------------------------------------
    logic tick;

    edge_rate_generator u_rate
    (
        .core_clk (core_clk),
        .rst (rst),
        .magnitude (mag_ff),
        .tick (tick)
    );

    // -----------------------------------------------------------------
    // quadrature sequencer
    // -----------------------------------------------------------------
    logic half_ff;
    logic [1:0] quad_ff;
    logic [1:0] nxt_quad;

    // ticks come at twice the track A rate of frequency mode, so every
    // second tick is one quadrature edge: 100 kHz edges, 25 kHz tracks
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            half_ff <= 1'b0;
        end
        else if (tick)
        begin
            half_ff <= ~half_ff; // R9
        end
    end

    // step forward for positive, backward for negative setpoints
    always_comb
    begin
        if (negative_ff)
        begin
            nxt_quad = 2'(quad_ff - 2'h1); // R6
        end
        else
        begin
            nxt_quad = 2'(quad_ff + 2'h1); // R6
        end
    end

    // sequence position; direction is read per step so a reversal keeps
    // the gray order and never makes a double edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            quad_ff <= 2'h0;
        end
        else if (tick && half_ff)
        begin
            quad_ff <= nxt_quad; // R4
        end
    end

    // -----------------------------------------------------------------
    // frequency track
    // -----------------------------------------------------------------
    logic freq_a_ff;

    // toggling on every tick gives 100 kHz at full scale, 1:1 duty
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            freq_a_ff <= `QPO_RST_A;
        end
        else if (tick)
        begin
            freq_a_ff <= ~freq_a_ff; // R7
        end
    end

    // -----------------------------------------------------------------
    // output formatter
    // -----------------------------------------------------------------
    logic nxt_a;
    logic nxt_b;

    // A = q1^q0, B = q1 walks 00,10,11,01: A rises a quarter before B
    always_comb
    begin
        case (mode_ff)
            quadrature_pulse_output_pkg::MODE_QUAD:
            begin
                nxt_a = quad_ff[1] ^ quad_ff[0]; // R5
                nxt_b = quad_ff[1]; // R4
            end
            quadrature_pulse_output_pkg::MODE_FREQ_SIGN:
            begin
                nxt_a = freq_a_ff; // R7
                nxt_b = negative_ff; // R8
            end
            default:
            begin
                nxt_a = `QPO_RST_A;
                nxt_b = `QPO_RST_B;
            end
        endcase
    end

    logic a_ff;
    logic b_ff;

    // track levels from flip-flops, glitch free at the line drivers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            a_ff <= `QPO_RST_A;
            b_ff <= `QPO_RST_B;
        end
        else
        begin
            a_ff <= nxt_a;
            b_ff <= nxt_b;
        end
    end

    logic an_ff;
    logic bn_ff;

    // inverted copies kept in their own flops so both legs switch together
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            an_ff <= ~`QPO_RST_A;
            bn_ff <= ~`QPO_RST_B;
        end
        else
        begin
            an_ff <= ~nxt_a; // R3
            bn_ff <= ~nxt_b; // R3
        end
    end

    assign enc_pins.a_p = a_ff;
    assign enc_pins.a_n = an_ff;
    assign enc_pins.b_p = b_ff;
    assign enc_pins.b_n = bn_ff;
    assign mode = mode_ff;

endmodule // quadrature_pulse_output
`default_nettype wire

// file: testbench/encoder_input_model.sv
// drive-side encoder input model: strap jumper and pulse pair decoder
`timescale 1ns/1ps
`default_nettype none

module encoder_input_model
(
    // clock and counter clear
    input wire logic core_clk,
    input wire logic clr,
    // jumper request and the strap pin it makes
    input wire logic jumper,
    output logic mode_strap_input,
    // received pulse pairs
    input wire quadrature_pulse_output_pkg::enc_pins_t pins,
    // decoded position and track A edge count
    output int pos,
    output int a_cnt
);
    logic [1:0] ab_ff;

    // open pin reads high through the pull-up, the jumper grounds it
    assign mode_strap_input = jumper ? 1'b0 : 1'b1;

    // x4 decode: an A edge away from B or a B edge onto A counts up
    always_ff @(posedge core_clk)
    begin
        ab_ff <= {pins.a_p, pins.b_p};
        if (clr)
        begin
            pos <= 0;
            a_cnt <= 0;
        end
        else if (pins.a_p != ab_ff[1])
        begin
            a_cnt <= a_cnt + 1;
            pos <= pos + ((pins.a_p != pins.b_p) ? 1 : -1);
        end
        else if (pins.b_p != ab_ff[0])
        begin
            pos <= pos + ((pins.a_p == pins.b_p) ? 1 : -1);
        end
    end
endmodule // encoder_input_model

`default_nettype wire

// file: testbench/quadrature_pulse_output_sva.sv
// port checker of the encoder emulation output stage
`timescale 1ns/1ps
`default_nettype none

module quadrature_pulse_output_sva
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // watched ports
    input wire quadrature_pulse_output_pkg::setpoint_t setpoint,
    input wire logic mode_strap_input,
    input wire quadrature_pulse_output_pkg::enc_pins_t enc_pins,
    input wire quadrature_pulse_output_pkg::mode_t mode
);
    logic sgn_ff;
    logic a_ff;
    logic [1:0] skip_ff;
    logic [9:0] run_ff;
    quadrature_pulse_output_pkg::mode_t mode_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // sign of the last loaded word
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sgn_ff <= 1'b0;
        end
        else if (setpoint.sync)
        begin
            sgn_ff <= setpoint.value[31];
        end
    end

    // run length of track A; a format switch can make the edge of the
    // switch itself and the next one early, so both are let through
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            a_ff <= 1'b0;
            skip_ff <= 2'h0;
            run_ff <= '0;
            mode_ff <= quadrature_pulse_output_pkg::MODE_QUAD;
        end
        else
        begin
            a_ff <= enc_pins.a_p;
            mode_ff <= mode;
            run_ff <= (enc_pins.a_p != a_ff) ? '0 : run_ff + {9'h0, ~&run_ff};
            if (mode != mode_ff)
            begin
                skip_ff <= 2'h2;
            end
            else if (enc_pins.a_p != a_ff && skip_ff != 2'h0)
            begin
                skip_ff <= skip_ff - 2'h1;
            end
        end
    end

    sequence s_quad;
        (mode == quadrature_pulse_output_pkg::MODE_QUAD && !setpoint.sync)[*3];
    endsequence
    sequence s_freq;
        (mode == quadrature_pulse_output_pkg::MODE_FREQ_SIGN
            && !setpoint.sync)[*3];
    endsequence

    property p_pair_a;
        enc_pins.a_n == !enc_pins.a_p;
    endproperty
    property p_pair_b;
        enc_pins.b_n == !enc_pins.b_p;
    endproperty
    property p_mode_quad;
        mode_strap_input [*4]
            |=> mode == quadrature_pulse_output_pkg::MODE_QUAD;
    endproperty
    property p_mode_freq;
        !mode_strap_input [*4]
            |=> mode == quadrature_pulse_output_pkg::MODE_FREQ_SIGN;
    endproperty
    property p_quad_step;
        s_quad |-> !($changed(enc_pins.a_p) && $changed(enc_pins.b_p));
    endproperty
    property p_dir;
        s_quad ##0 $changed(enc_pins.a_p)
            |-> (enc_pins.a_p != enc_pins.b_p) == !sgn_ff;
    endproperty
    property p_sign_b;
        s_freq |-> enc_pins.b_p == sgn_ff;
    endproperty
    property p_min_run;
        (enc_pins.a_p != a_ff && skip_ff == 2'h0) |-> run_ff >= 10'd177;
    endproperty

    a_pair_a:
    assert property (p_pair_a) else $error("track A pair not inverse");
    a_pair_b:
    assert property (p_pair_b) else $error("track B pair not inverse");
    a_mode_quad:
    assert property (p_mode_quad) else $error("open strap left other mode");
    a_mode_freq:
    assert property (p_mode_freq) else $error("grounded strap ignored");
    a_quad_step:
    assert property (p_quad_step) else $error("both tracks moved at once");
    a_dir:
    assert property (p_dir) else $error("track order against sign");
    a_sign_b:
    assert property (p_sign_b) else $error("track B not the sign");
    a_min_run:
    assert property (p_min_run) else $error("track A faster than clamp");
endmodule // quadrature_pulse_output_sva

bind quadrature_pulse_output quadrature_pulse_output_sva chk
(
    .core_clk(core_clk),
    .rst(rst),
    .setpoint(setpoint),
    .mode_strap_input(mode_strap_input),
    .enc_pins(enc_pins),
    .mode(mode)
);

`default_nettype wire

// file: testbench/quadrature_pulse_output_tb_top.sv
// self-checking bench of the encoder emulation output stage
`timescale 1ns/1ps
`default_nettype none

module quadrature_pulse_output_tb_top;
    localparam int WIN = 8000;
    logic core_clk;
    logic rst;
    logic jumper;
    logic clr;
    logic mode_strap_input;
    quadrature_pulse_output_pkg::setpoint_t setpoint;
    quadrature_pulse_output_pkg::enc_pins_t enc_pins;
    quadrature_pulse_output_pkg::mode_t mode;
    int pos;
    int a_cnt;
    int error_cnt;
    int checks;
    logic [31:0] cases [8] = '{32'h4000_0000, 32'hc000_0000, 32'h47c0_0000,
        32'hb840_0000, 32'h7fc0_0000, 32'h8000_0000, 32'h0, 32'h003f_ffff};

    quadrature_pulse_output dut (.core_clk(core_clk), .rst(rst),
        .setpoint(setpoint), .mode_strap_input(mode_strap_input),
        .enc_pins(enc_pins), .mode(mode));
    encoder_input_model drive (.core_clk(core_clk), .clr(clr),
        .jumper(jumper), .mode_strap_input(mode_strap_input),
        .pins(enc_pins), .pos(pos), .a_cnt(a_cnt));

    // ----------------------------------------
    // expectations and checking
    // ----------------------------------------
    // ten top bits, magnitude clamped at about 112 percent
    function automatic int exp_mag(input logic [31:0] v);
        int f;
        f = $signed(v[31:22]);
        f = (f < 0) ? -f : f;
        return (f > 287) ? 287 : f;
    endfunction

    // accumulator phase is not reset, so one step either way is fair
    function automatic int near(input int s, input int e);
        return (s - e <= 1 && e - s <= 1) ? e : s;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // bounded wait for the strap to take effect
    // mode is looked at 1 ns after each edge, where it has settled
    task automatic wait_mode(input quadrature_pulse_output_pkg::mode_t m);
        int n;
        n = 0;
        #1;
        while (mode !== m && n < 8)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(mode, m);
        if (mode !== m)
            close_out();
        @(posedge core_clk);
    endtask

    // a stray word strobed just before the real one must not survive
    task automatic run_case(input logic [31:0] v, input logic fs);
        int e;
        @(posedge core_clk);
        jumper <= fs;
        @(posedge core_clk);
        wait_mode(fs ? quadrature_pulse_output_pkg::MODE_FREQ_SIGN
            : quadrature_pulse_output_pkg::MODE_QUAD);
        setpoint <= {~v, 1'b1};
        @(posedge core_clk);
        setpoint <= {v, 1'b1};
        clr <= 1'b1;
        @(posedge core_clk);
        setpoint.sync <= 1'b0;
        repeat (4) @(posedge core_clk);
        clr <= 1'b0;
        repeat (WIN) @(posedge core_clk);
        #1;
        e = WIN * exp_mag(v) / (fs ? 51200 : 102400);
        if (fs)
        begin
            chk(near(a_cnt, e), e);
            chk(enc_pins.b_p, v[31]);
        end
        else
        begin
            chk(near(pos, v[31] ? -e : e), v[31] ? -e : e);
            chk(near(a_cnt, e / 2), e / 2);
        end
    endtask

    // ----------------------------------------
    // clock and main sequence
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // corner words first, each sign in each format, then random words
    initial
    begin
        logic [31:0] v;
        rst = 1'b1;
        jumper = 1'b0;
        clr = 1'b1;
        setpoint = '0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(67));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(enc_pins, 4'h5);
        chk(mode, quadrature_pulse_output_pkg::MODE_QUAD);
        for (int i = 0; i < 10; i++)
        begin
            v = (i < 8) ? cases[i] : $urandom;
            run_case(v, (i < 8) ? i[1] : 1'($urandom_range(1, 0)));
        end
        close_out();
    end
endmodule // quadrature_pulse_output_tb_top

`default_nettype wire
